/* design/atcs_regs.sv */
// Trim, aperture delay and clock-sync control registers with decoded settings
// Assumes a synchronous word port from the serial control interface decoder;
// sync_ref_in_i and output_clock_resync_i are pins, synchronised here
// ==========================================
// What this block does
// RULE1 - Host writes zero to offset word bits 15:13; device stores them as zero.
// RULE2 - Offset sign zero adds the offset, one subtracts it.
// RULE3 - Offset magnitude is unsigned twelve bit, zero means no offset.
// RULE4 - Full-scale magnitude is unsigned fifteen bit, reset code 16384.
// RULE5 - Host keeps full-scale word bit 15 zero.
// RULE6 - Coarse delay grows with code, saturating at code 2432 and above.
// RULE7 - Delay codes apply only while either select bit is set.
// RULE8 - Duty stabiliser enabled while its bit is one, the reset value.
// RULE9 - Host writes zero to coarse word bits 1:0.
// RULE10 - Fine delay code adds extra delay while delay feature selected.
// RULE11 - Host writes zero to fine word bit 9.
// RULE12 - Filter select enables delay and tank filter, ignoring adjust select.
// RULE13 - Tank select is a thermometer code, zeros highest frequency.
// RULE14 - Reference delay follows code, saturating at 639 and above.
// RULE15 - Latch phase code selects 0, 90, 180 or 270 degrees.
// RULE16 - Slave bit aligns divided clocks to incoming reference, else master.
// RULE17 - Reference outputs carry clock divided by four unless disabled.
// RULE18 - Resync input ignored while its disable bit is one.
// RULE19 - Host writes zero to sync word bit 5.
// RULE20 - Last word is read-only, returns 000C hex, ignores writes.
// RULE21 - All registers load power-on values and hold written values.
`timescale 1ns/100ps
module atcs_regs
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wr_data_i,
    output logic [15:0] rd_data_o,
    input wire logic sync_ref_in_i,
    input wire logic output_clock_resync_i,
    output logic offset_negative_o,
    output logic [11:0] offset_magnitude_o,
    output logic [14:0] fsr_magnitude_o,
    output logic delay_enable_o,
    output logic [11:0] coarse_delay_eff_o,
    output logic [5:0] fine_delay_eff_o,
    output logic duty_stabilizer_on_o,
    output logic tank_filter_on_o,
    output logic [3:0] tank_level_o,
    output logic tank_code_valid_o,
    output logic [9:0] ref_delay_eff_o,
    output logic [3:0] latch_phase_onehot_o,
    output logic slave_mode_o,
    output logic sync_ref_out_a_o,
    output logic sync_ref_out_b_o,
    output logic resync_pulse_o
);
    // ==========================================
    // Register state
    logic [15:0] q_offset_adjust;
    logic [15:0] q_full_scale_adjust;
    logic [15:0] aperture_coarse_delay;
    logic [15:0] aperture_fine_and_filter;
    logic [15:0] multichip_sync_control;
    logic [15:0] next_q_offset_adjust;
    logic [15:0] next_q_full_scale_adjust;
    logic [15:0] next_aperture_coarse_delay;
    logic [15:0] next_aperture_fine_and_filter;
    logic [15:0] next_multichip_sync_control;
    logic [15:0] next_rd_data;

    // Write decode; reserved bits are masked off so they read back zero
    always_comb
    begin
        next_q_offset_adjust = q_offset_adjust;
        next_q_full_scale_adjust = q_full_scale_adjust;
        next_aperture_coarse_delay = aperture_coarse_delay;
        next_aperture_fine_and_filter = aperture_fine_and_filter;
        next_multichip_sync_control = multichip_sync_control;
        if (wr_en_i)
        begin
            case (addr_i)
                atcs_pkg::ADDR_Q_OFFSET_ADJUST:
                    next_q_offset_adjust = wr_data_i & atcs_pkg::MASK_Q_OFFSET_ADJUST; // RULE1
                atcs_pkg::ADDR_Q_FULL_SCALE_ADJUST:
                    next_q_full_scale_adjust = wr_data_i & atcs_pkg::MASK_Q_FULL_SCALE_ADJUST; // RULE5
                atcs_pkg::ADDR_APERTURE_COARSE_DELAY:
                    next_aperture_coarse_delay = wr_data_i & atcs_pkg::MASK_APERTURE_COARSE_DELAY; // RULE9
                atcs_pkg::ADDR_APERTURE_FINE_AND_FILTER:
                    next_aperture_fine_and_filter =
                        wr_data_i & atcs_pkg::MASK_APERTURE_FINE_AND_FILTER; // RULE11
                atcs_pkg::ADDR_MULTICHIP_SYNC_CONTROL:
                    next_multichip_sync_control =
                        wr_data_i & atcs_pkg::MASK_MULTICHIP_SYNC_CONTROL; // RULE19
                default:
                    next_q_offset_adjust = q_offset_adjust; // RULE20
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (addr_i)
            atcs_pkg::ADDR_Q_OFFSET_ADJUST: next_rd_data = q_offset_adjust;
            atcs_pkg::ADDR_Q_FULL_SCALE_ADJUST: next_rd_data = q_full_scale_adjust;
            atcs_pkg::ADDR_APERTURE_COARSE_DELAY: next_rd_data = aperture_coarse_delay;
            atcs_pkg::ADDR_APERTURE_FINE_AND_FILTER: next_rd_data = aperture_fine_and_filter;
            atcs_pkg::ADDR_MULTICHIP_SYNC_CONTROL: next_rd_data = multichip_sync_control;
            atcs_pkg::ADDR_RESERVED_READONLY_WORD:
                next_rd_data = atcs_pkg::VAL_RESERVED_READONLY_WORD; // RULE20
            default: next_rd_data = 16'h0000;
        endcase
    end

    // Register update
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q_offset_adjust <= atcs_pkg::RST_Q_OFFSET_ADJUST; // RULE21
            q_full_scale_adjust <= atcs_pkg::RST_Q_FULL_SCALE_ADJUST; // RULE4
            aperture_coarse_delay <= atcs_pkg::RST_APERTURE_COARSE_DELAY; // RULE8
            aperture_fine_and_filter <= atcs_pkg::RST_APERTURE_FINE_AND_FILTER;
            multichip_sync_control <= atcs_pkg::RST_MULTICHIP_SYNC_CONTROL; // RULE17
            rd_data_o <= 16'h0000;
        end
        else
        begin
            q_offset_adjust <= next_q_offset_adjust; // RULE21
            q_full_scale_adjust <= next_q_full_scale_adjust;
            aperture_coarse_delay <= next_aperture_coarse_delay;
            aperture_fine_and_filter <= next_aperture_fine_and_filter;
            multichip_sync_control <= next_multichip_sync_control;
            rd_data_o <= next_rd_data;
        end
    end

    // ==========================================
    // Pin synchronisers and reference-clock divider
    logic [1:0] ref_sync;
    logic [1:0] rst_sync;
    logic rst_seen;
    logic [1:0] div_cnt;
    logic [1:0] next_div_cnt;
    logic ref_prev;
    logic slave_bit;

    assign slave_bit = multichip_sync_control[atcs_pkg::SLAVE_BIT];

    // Divider by four; in slave mode a reference rising edge realigns it
    always_comb
    begin
        next_div_cnt = div_cnt + 2'h1;
        if (slave_bit && ref_sync[1] && !ref_prev)
        begin
            next_div_cnt = 2'h0; // RULE16
        end
    end

    // Synchroniser and divider registers
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ref_sync <= 2'h0;
            rst_sync <= 2'h0;
            rst_seen <= 1'b0;
            ref_prev <= 1'b0;
            div_cnt <= 2'h0;
        end
        else
        begin
            ref_sync <= {ref_sync[0], sync_ref_in_i};
            rst_sync <= {rst_sync[0], output_clock_resync_i};
            rst_seen <= rst_sync[1];
            ref_prev <= ref_sync[1];
            div_cnt <= next_div_cnt;
        end
    end

    // ==========================================
    // Decoded settings, registered
    logic filt_sel;
    logic dly_en;
    logic [11:0] coarse_raw;
    logic [9:0] ref_raw;
    logic [7:0] tank_raw;
    logic [3:0] tank_cnt;
    logic tank_ok;
    logic [7:0] therm_chk;
    logic ref_out;
    logic next_offset_negative;
    logic [11:0] next_offset_magnitude;
    logic [14:0] next_fsr_magnitude;
    logic next_delay_enable;
    logic [11:0] next_coarse_delay_eff;
    logic [5:0] next_fine_delay_eff;
    logic next_duty_stabilizer_on;
    logic next_tank_filter_on;
    logic [3:0] next_tank_level;
    logic next_tank_code_valid;
    logic [9:0] next_ref_delay_eff;
    logic [3:0] next_latch_phase_onehot;
    logic next_slave_mode;
    logic next_sync_ref_out;
    logic next_resync_pulse;

    assign filt_sel = aperture_fine_and_filter[atcs_pkg::FILT_SEL_BIT];
    // Filter select overrides adjust select
    assign dly_en = filt_sel | aperture_coarse_delay[atcs_pkg::ADJ_SEL_BIT]; // RULE7 RULE12
    assign coarse_raw = aperture_coarse_delay[15:atcs_pkg::COARSE_LSB];
    assign ref_raw = multichip_sync_control[15:atcs_pkg::REF_DLY_LSB];
    assign tank_raw = aperture_fine_and_filter[atcs_pkg::TANK_BITS-1:0];
    assign ref_out = div_cnt[1] & ~multichip_sync_control[atcs_pkg::REF_OUT_DIS_BIT]; // RULE17

    // Thermometer check: every set bit lies below every clear bit
    genvar gi;
    generate
        for (gi = 0; gi < atcs_pkg::TANK_BITS; gi++)
        begin : g_therm
            assign therm_chk[gi] = (tank_raw[gi] == (gi < tank_cnt)); // RULE13
        end
    endgenerate

    // Count of set thermometer bits
    always_comb
    begin
        tank_cnt = 4'h0;
        for (int i = 0; i < atcs_pkg::TANK_BITS; i++)
        begin
            tank_cnt = tank_cnt + {3'h0, tank_raw[i]};
        end
    end

    // Valid only when the set bits form one unbroken run from bit zero
    assign tank_ok = &therm_chk; // RULE13

    // Next values of the decoded settings; registering them keeps the trims
    // free of glitches while a word is rewritten
    always_comb
    begin
        next_offset_negative = q_offset_adjust[atcs_pkg::OFFSET_SIGN_BIT]; // RULE2
        next_offset_magnitude = q_offset_adjust[11:0]; // RULE3
        next_fsr_magnitude = q_full_scale_adjust[14:0]; // RULE4
        next_delay_enable = dly_en; // RULE7
        // Saturating coarse delay, zero when not selected
        next_coarse_delay_eff = !dly_en ? 12'h000 :
            (coarse_raw >= atcs_pkg::COARSE_MAX) ? atcs_pkg::COARSE_MAX : coarse_raw; // RULE6
        // Fine delay follows the same enable as the coarse delay
        next_fine_delay_eff = dly_en ?
            aperture_fine_and_filter[15:atcs_pkg::FINE_LSB] : 6'h00; // RULE10
        next_duty_stabilizer_on = aperture_coarse_delay[atcs_pkg::DUTY_BIT]; // RULE8
        next_tank_filter_on = filt_sel; // RULE12
        next_tank_level = tank_cnt; // RULE13
        next_tank_code_valid = tank_ok;
        // Saturating reference delay
        next_ref_delay_eff = (ref_raw >= atcs_pkg::REF_DLY_MAX) ?
            atcs_pkg::REF_DLY_MAX : ref_raw; // RULE14
        next_latch_phase_onehot = 4'h1 <<
            multichip_sync_control[atcs_pkg::PHASE_LSB +: 2]; // RULE15
        next_slave_mode = slave_bit; // RULE16
        next_sync_ref_out = ref_out; // RULE17
        // One pulse per synchronised rising edge of the resync pin, when enabled
        next_resync_pulse = rst_sync[1] & ~rst_seen &
            ~multichip_sync_control[atcs_pkg::RESYNC_DIS_BIT]; // RULE18
    end

    // Settings outputs
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            offset_negative_o <= 1'b0;
            offset_magnitude_o <= 12'h000;
            fsr_magnitude_o <= atcs_pkg::RST_Q_FULL_SCALE_ADJUST[14:0]; // RULE4
            delay_enable_o <= 1'b0;
            coarse_delay_eff_o <= 12'h000;
            fine_delay_eff_o <= 6'h00;
            duty_stabilizer_on_o <=
                atcs_pkg::RST_APERTURE_COARSE_DELAY[atcs_pkg::DUTY_BIT]; // RULE8
            tank_filter_on_o <= 1'b0;
            tank_level_o <= 4'h0;
            tank_code_valid_o <= 1'b1;
            ref_delay_eff_o <= 10'h000;
            latch_phase_onehot_o <= 4'h1;
            slave_mode_o <= 1'b0;
            sync_ref_out_a_o <= 1'b0;
            sync_ref_out_b_o <= 1'b0;
            resync_pulse_o <= 1'b0;
        end
        else
        begin
            offset_negative_o <= next_offset_negative;
            offset_magnitude_o <= next_offset_magnitude;
            fsr_magnitude_o <= next_fsr_magnitude;
            delay_enable_o <= next_delay_enable;
            coarse_delay_eff_o <= next_coarse_delay_eff;
            fine_delay_eff_o <= next_fine_delay_eff;
            duty_stabilizer_on_o <= next_duty_stabilizer_on;
            tank_filter_on_o <= next_tank_filter_on;
            tank_level_o <= next_tank_level;
            tank_code_valid_o <= next_tank_code_valid;
            ref_delay_eff_o <= next_ref_delay_eff;
            latch_phase_onehot_o <= next_latch_phase_onehot;
            slave_mode_o <= next_slave_mode;
            sync_ref_out_a_o <= next_sync_ref_out;
            sync_ref_out_b_o <= next_sync_ref_out;
            resync_pulse_o <= next_resync_pulse;
        end
    end
endmodule // atcs_regs

/* inc/atcs_pkg.sv */
// Register map, field layout and reset values of the trim and clock-sync register group
// Assumes a 16-bit word register port with 4-bit word addresses
package atcs_pkg;
    // ==========================================
    // Word addresses
    localparam logic [3:0] ADDR_Q_OFFSET_ADJUST = 4'hA;
    localparam logic [3:0] ADDR_Q_FULL_SCALE_ADJUST = 4'hB;
    localparam logic [3:0] ADDR_APERTURE_COARSE_DELAY = 4'hC;
    localparam logic [3:0] ADDR_APERTURE_FINE_AND_FILTER = 4'hD;
    localparam logic [3:0] ADDR_MULTICHIP_SYNC_CONTROL = 4'hE;
    localparam logic [3:0] ADDR_RESERVED_READONLY_WORD = 4'hF;
    // ==========================================
    // Reset values
    localparam logic [15:0] RST_Q_OFFSET_ADJUST = 16'h0000;
    localparam logic [15:0] RST_Q_FULL_SCALE_ADJUST = 16'h4000;
    localparam logic [15:0] RST_APERTURE_COARSE_DELAY = 16'h0004;
    localparam logic [15:0] RST_APERTURE_FINE_AND_FILTER = 16'h0000;
    localparam logic [15:0] RST_MULTICHIP_SYNC_CONTROL = 16'h0003;
    localparam logic [15:0] VAL_RESERVED_READONLY_WORD = 16'h000C;
    // ==========================================
    // Writable-bit masks (reserved bits stored as zero)
    localparam logic [15:0] MASK_Q_OFFSET_ADJUST = 16'h1FFF;
    localparam logic [15:0] MASK_Q_FULL_SCALE_ADJUST = 16'h7FFF;
    localparam logic [15:0] MASK_APERTURE_COARSE_DELAY = 16'hFFFC;
    localparam logic [15:0] MASK_APERTURE_FINE_AND_FILTER = 16'hFDFF;
    localparam logic [15:0] MASK_MULTICHIP_SYNC_CONTROL = 16'hFFDF;
    // ==========================================
    // Field positions
    localparam int OFFSET_SIGN_BIT = 12;
    localparam int COARSE_LSB = 4;
    localparam int ADJ_SEL_BIT = 3;
    localparam int DUTY_BIT = 2;
    localparam int FINE_LSB = 10;
    localparam int FILT_SEL_BIT = 8;
    localparam int REF_DLY_LSB = 6;
    localparam int PHASE_LSB = 3;
    localparam int SLAVE_BIT = 2;
    localparam int REF_OUT_DIS_BIT = 1;
    localparam int RESYNC_DIS_BIT = 0;
    // ==========================================
    // Saturation points
    localparam logic [11:0] COARSE_MAX = 12'h0980;
    localparam logic [9:0] REF_DLY_MAX = 10'h027F;
    // Thermometer code widths
    localparam int TANK_BITS = 8;
endpackage

/* tb/atcs_regs_sva.sv */
// Checker for the trim and clock-sync register group
// Assumes it is bound to atcs_regs and sees only its ports
`timescale 1ns/100ps
module atcs_regs_sva
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [15:0] rd_data_o,
    input wire logic [14:0] fsr_magnitude_o,
    input wire logic delay_enable_o,
    input wire logic [11:0] coarse_delay_eff_o,
    input wire logic [5:0] fine_delay_eff_o,
    input wire logic duty_stabilizer_on_o,
    input wire logic [9:0] ref_delay_eff_o,
    input wire logic [3:0] latch_phase_onehot_o,
    input wire logic sync_ref_out_a_o,
    input wire logic resync_pulse_o
);
    // ====================
    // Shadow words and quiet-time counter; s marks settled outputs
    logic [15:0] sh_b, sh_c, sh_d, sh_e;
    logic [1:0] quiet;
    logic s, en;
    assign s = quiet == 2'h3;
    assign en = sh_c[3] | sh_d[8];
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sh_b <= 16'h4000;
            sh_c <= 16'h0004;
            sh_d <= 16'h0000;
            sh_e <= 16'h0003;
            quiet <= 2'h0;
        end
        else
        begin
            quiet <= wr_en_i ? 2'h0 : (s ? quiet : quiet + 2'h1);
            if (wr_en_i && addr_i == 4'hB) sh_b <= wr_data_i;
            if (wr_en_i && addr_i == 4'hC) sh_c <= wr_data_i;
            if (wr_en_i && addr_i == 4'hD) sh_d <= wr_data_i;
            if (wr_en_i && addr_i == 4'hE) sh_e <= wr_data_i;
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence quarter_wave;
        sync_ref_out_a_o ##1 !sync_ref_out_a_o;
    endsequence
    fsr_trim_a: assert property (s |-> fsr_magnitude_o == sh_b[14:0])
        else $error("full-scale output differs from written code");
    coarse_sat_a: assert property (s |-> coarse_delay_eff_o == (!en ? 12'h000 :
        (sh_c[15:4] >= 12'h980 ? 12'h980 : sh_c[15:4]))) else $error("coarse delay wrong");
    fine_gate_a: assert property (s |-> delay_enable_o == en &&
        fine_delay_eff_o == (en ? sh_d[15:10] : 6'h00)) else $error("fine delay gating wrong");
    duty_bit_a: assert property (s |-> duty_stabilizer_on_o == sh_c[2])
        else $error("duty stabiliser state wrong");
    ref_sat_a: assert property (s |-> ref_delay_eff_o ==
        (sh_e[15:6] >= 10'h27F ? 10'h27F : sh_e[15:6])) else $error("reference delay wrong");
    phase_sel_a: assert property (s |-> latch_phase_onehot_o == (4'h1 << sh_e[4:3]))
        else $error("latch phase select wrong");
    ref_wave_a: assert property ($rose(sync_ref_out_a_o) && s && !sh_e[2] |=> quarter_wave)
        else $error("reference output not quarter rate");
    resync_gate_a: assert property (resync_pulse_o && s |-> !sh_e[0])
        else $error("resync pulse while disabled");
    ro_word_a: assert property (addr_i == 4'hF |=> rd_data_o == 16'h000C)
        else $error("read-only word wrong");
    rst_vals_a: assert property ($fell(rst_i) |-> fsr_magnitude_o == 15'h4000 &&
        duty_stabilizer_on_o && !sync_ref_out_a_o) else $error("power-on values wrong");
endmodule // atcs_regs_sva

bind atcs_regs atcs_regs_sva u_sva
(
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .fsr_magnitude_o(fsr_magnitude_o),
    .delay_enable_o(delay_enable_o), .coarse_delay_eff_o(coarse_delay_eff_o),
    .fine_delay_eff_o(fine_delay_eff_o), .duty_stabilizer_on_o(duty_stabilizer_on_o),
    .ref_delay_eff_o(ref_delay_eff_o), .latch_phase_onehot_o(latch_phase_onehot_o),
    .sync_ref_out_a_o(sync_ref_out_a_o), .resync_pulse_o(resync_pulse_o)
);

/* tb/atcs_host_model.sv */
// Host model of the register port: word writes and reads
// Assumes the device samples on rising clk_sys_i edges
`timescale 1ns/100ps
module atcs_host_model
(
    input wire logic clk_sys_i,
    input wire logic [15:0] rd_data_o,
    output logic wr_en_i,
    output logic [3:0] addr_i,
    output logic [15:0] wr_data_i
);
    // ====================
    // Idle bus at time zero
    initial
    begin
        wr_en_i = 1'b0;
        addr_i = 4'h0;
        wr_data_i = 16'h0000;
    end
    // Reserved bits always sent as zero
    function automatic logic [15:0] keep(input logic [3:0] a);
        case (a)
            4'hA: keep = 16'h1FFF;
            4'hB: keep = 16'h7FFF;
            4'hC: keep = 16'hFFFC;
            4'hD: keep = 16'hFDFF;
            4'hE: keep = 16'hFFDF;
            default: keep = 16'hFFFF;
        endcase
    endfunction
    // One-cycle strobe; data inverted once released
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        #1;
        wr_en_i = 1'b1;
        addr_i = a;
        wr_data_i = d & keep(a);
        @(posedge clk_sys_i);
        #1;
        wr_en_i = 1'b0;
        wr_data_i = ~wr_data_i;
    endtask
    // Address first, data taken one edge later
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        #1;
        addr_i = a;
        @(posedge clk_sys_i);
        #1;
        d = rd_data_o;
    endtask
endmodule // atcs_host_model

/* tb/tb.sv */
// Self-checking bench for the trim and clock-sync register group
// Assumes the host model drives the register port and the checker is bound
`timescale 1ns/100ps
module tb;
    // ====================
    // Signals and expectations
    logic clk_sys_i = 1'b0, rst_i = 1'b1, sync_ref_in_i = 1'b0, output_clock_resync_i = 1'b0;
    logic wr_en_i, offset_negative_o, delay_enable_o, duty_stabilizer_on_o, tank_filter_on_o;
    logic tank_code_valid_o, slave_mode_o, sync_ref_out_a_o, sync_ref_out_b_o, resync_pulse_o;
    logic [3:0] addr_i, tank_level_o, latch_phase_onehot_o;
    logic [15:0] wr_data_i, rd_data_o, d;
    logic [11:0] offset_magnitude_o, coarse_delay_eff_o;
    logic [14:0] fsr_magnitude_o;
    logic [5:0] fine_delay_eff_o;
    logic [9:0] ref_delay_eff_o;
    int mismatches = 0, compares = 0, n, m;
    localparam logic [15:0] RV [6] = '{16'h0000, 16'h4000, 16'h0004, 16'h0000, 16'h0003, 16'h000C};
    localparam logic [15:0] WV [6] = '{16'h1ABC, 16'h7FFF, 16'hFFF8, 16'hFD0F, 16'hFFD0, 16'h000C};
    // Clock and instances
    always #25 clk_sys_i = ~clk_sys_i;
    atcs_regs DUT
    (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .sync_ref_in_i(sync_ref_in_i),
        .output_clock_resync_i(output_clock_resync_i), .offset_negative_o(offset_negative_o),
        .offset_magnitude_o(offset_magnitude_o), .fsr_magnitude_o(fsr_magnitude_o),
        .delay_enable_o(delay_enable_o), .coarse_delay_eff_o(coarse_delay_eff_o),
        .fine_delay_eff_o(fine_delay_eff_o), .duty_stabilizer_on_o(duty_stabilizer_on_o),
        .tank_filter_on_o(tank_filter_on_o), .tank_level_o(tank_level_o),
        .tank_code_valid_o(tank_code_valid_o), .ref_delay_eff_o(ref_delay_eff_o),
        .latch_phase_onehot_o(latch_phase_onehot_o), .slave_mode_o(slave_mode_o),
        .sync_ref_out_a_o(sync_ref_out_a_o), .sync_ref_out_b_o(sync_ref_out_b_o),
        .resync_pulse_o(resync_pulse_o)
    );
    atcs_host_model u_host
    (
        .clk_sys_i(clk_sys_i), .rd_data_o(rd_data_o), .wr_en_i(wr_en_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i)
    );
    // ====================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) mismatches++;
        if (seen !== exp) $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic put(input logic [3:0] a, input logic [15:0] v);
        u_host.wr(a, v);
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    // Reference output edges over 16 cycles; 99 if the pair differs
    task automatic toggles(output int t);
        logic p;
        t = 0;
        p = sync_ref_out_a_o;
        repeat (16)
        begin
            @(posedge clk_sys_i);
            #1;
            if (sync_ref_out_a_o !== p) t++;
            if (sync_ref_out_a_o !== sync_ref_out_b_o) t = 99;
            p = sync_ref_out_a_o;
        end
    endtask
    // One rise of the resync pin; counts pulses seen
    task automatic pulses(output int t);
        t = 0;
        output_clock_resync_i = 1'b1;
        repeat (12)
        begin
            @(posedge clk_sys_i);
            #1;
            if (resync_pulse_o === 1'b1) t++;
        end
        output_clock_resync_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1;
    endtask
    // One rise of the reference pin, then the reference output over four cycles as bits
    task automatic realign(output int t);
        t = 0;
        sync_ref_in_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        repeat (4)
        begin
            @(posedge clk_sys_i);
            #1;
            t = t * 2 + ((sync_ref_out_a_o === 1'b1) ? 1 : 0);
        end
        sync_ref_in_i = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    // ====================
    // Hang guard
    initial
    begin
        #1000000;
        mismatches++;
        report_and_stop;
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        chk("fsr_reset", 16'(fsr_magnitude_o), 16'h4000);
        chk("duty_refout", 16'({sync_ref_out_a_o, duty_stabilizer_on_o}), 16'h0001);
        for (int i = 0; i < 6; i++)
        begin
            u_host.rd(4'hA + 4'(i), d);
            chk("reset_word", d, RV[i]);
        end
        $display("test reset values done");
        for (int i = 0; i < 6; i++) u_host.wr(4'hA + 4'(i), i == 5 ? 16'hFFFF : WV[i]);
        u_host.wr(4'h3, 16'h1234);
        for (int i = 0; i < 6; i++)
        begin
            u_host.rd(4'hA + 4'(i), d);
            chk("readback", d, WV[i]);
        end
        $display("test readback done");
        chk("offset", 16'({offset_negative_o, offset_magnitude_o}), 16'h1ABC);
        chk("fsr", 16'(fsr_magnitude_o), 16'h7FFF);
        chk("coarse", 16'(coarse_delay_eff_o), 16'h0980);
        chk("fine", 16'({delay_enable_o, tank_filter_on_o, fine_delay_eff_o}), 16'h00FF);
        chk("tank", 16'({tank_code_valid_o, tank_level_o}), 16'h0014);
        chk("ref_delay", 16'(ref_delay_eff_o), 16'h027F);
        chk("duty_mode", 16'({duty_stabilizer_on_o, slave_mode_o}), 16'h0000);
        toggles(n);
        chk("quarter_rate", 16'(n), 16'h0008);
        pulses(n);
        chk("resync_on", 16'(n), 16'h0001);
        $display("test decode done");
        put(4'hC, 16'h97F0);
        chk("filter_sel", 16'(coarse_delay_eff_o), 16'h097F);
        put(4'hD, 16'hFC0B);
        chk("gated", 16'({delay_enable_o, fine_delay_eff_o}), 16'h0000);
        chk("tank_bad", 16'({tank_code_valid_o, tank_level_o}), 16'h0003);
        for (int p = 0; p < 4; p++)
        begin
            put(4'hE, 16'h9F87 | 16'(p << 3));
            chk("phase",
                16'({slave_mode_o, latch_phase_onehot_o, ref_delay_eff_o}),
                16'({1'b1, 4'(1 << p), 10'h27E}));
            chk("ref_off", 16'({sync_ref_out_a_o, sync_ref_out_b_o}), 16'h0000);
        end
        pulses(n);
        chk("resync_off", 16'(n), 16'h0000);
        put(4'hE, 16'h0004);
        realign(n);
        realign(m);
        chk("realign", 16'(n), 16'h0006);
        chk("realign_again", 16'(m), 16'h0006);
        $display("test gating done");
        report_and_stop;
    end
endmodule // tb
